// ---- logic/jcu_defines.vh ----
// Shared constants for the debug-link character UART.
`ifndef JCU_DEFINES_VH
`define JCU_DEFINES_VH

`define JCU_DATA_ADDR     32'h10001000
`define JCU_CTRL_ADDR     32'h10001004

`define JCU_FIFO_DEPTH    64
`define JCU_FIFO_AW       6
`define JCU_FIFO_CW       7
`define JCU_SKID_DEPTH    2
`define JCU_SKID_AW       1
`define JCU_SKID_CW       2

`define JCU_CHAR_W        8
`define JCU_CHAR_LSB      0
`define JCU_CHAR_MSB      7
`define JCU_FIELD_W       16
`define JCU_FIELD_LSB     16
`define JCU_FIELD_MSB     31
`define JCU_RX_VALID_BIT  15

`define JCU_RX_IE_BIT     0
`define JCU_TX_IE_BIT     1
`define JCU_RX_IP_BIT     8
`define JCU_TX_IP_BIT     9
`define JCU_HOST_SEEN_BIT 10

`define JCU_IRQ_LEVEL     7

`define JCU_FRAME_W       9
`define JCU_BIT_W         4
`define JCU_LAST_BIT      4'h8
`define JCU_SYNC_W        3
`define JCU_WORD_ZERO     32'h00000000

`endif

// ---- logic/jcu_fifo.v ----
// Flip-flop FIFO with valid/ready on both sides and an occupancy count.
module jcu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter CW    = 7
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [CW-1:0]    count
);

  // DEPTH must be a power of two so that the pointers wrap by themselves.
  localparam [CW-1:0] FULL_C = DEPTH;
  localparam [CW-1:0] ONE_C  = 1;
  localparam [AW-1:0] STEP_C = 1;

  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wr_q;
  reg  [AW-1:0]    rd_q;
  reg  [CW-1:0]    cnt_q;
  wire             push;
  wire             pop;

  assign in_ready  = (cnt_q != FULL_C);
  assign out_valid = (cnt_q != {CW{1'b0}});
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {CW{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + STEP_C;
      end
      if (pop) begin
        rd_q <= rd_q + STEP_C;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + ONE_C;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - ONE_C;
      end
    end
  end

endmodule

// ---- logic/jcu_uart.v ----
// Character UART between the processor bus and a host debug link.
//
// Operation
// [R01] Two 32-bit registers: data and control.
// [R02] Host characters land in a 64-entry FIFO.
// [R03] Data bits 31:16 give receive count.
// [R04] Character arriving at full receive FIFO dropped.
// [R05] Bit 15 set whenever receive FIFO not empty.
// [R06] Data read pops oldest, shows decremented count.
// [R07] Empty FIFO read: valid bit zero.
// [R08] Data write pushes byte to transmit FIFO.
// [R09] Data write leaves receive side untouched.
// [R10] Control bits 31:16 give transmit free room.
// [R11] Write to full transmit FIFO is dropped.
// [R12] Host link access sets host_seen bit 10.
// [R13] Writing one clears host_seen; zero keeps.
// [R14] Enables at bits 0,1; pending at 8,9.
// [R15] Enabled interrupt raised while level exceeds seven.
// [R16] Pending clears as software moves characters.
// [R17] Interrupt output ORs enabled pending bits.
// [R18] Host fills only with room, drains in order.
//
// Link frame: while link_frame is high the host gives nine link_clk
// rising edges. Bit 0 is a carry flag each way, bits 1..8 the character
// LSB first. The host samples link_dout on rising edges; this block
// changes it after falling edges.
//
// The plain strobed port was decided locally.
`include "jcu_defines.vh"

module jcu_uart #(
  parameter DEPTH = `JCU_FIFO_DEPTH,
  parameter AW    = `JCU_FIFO_AW,
  parameter CW    = `JCU_FIFO_CW
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [31:0] bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire        bus_we,
  input  wire        bus_re,
  output wire [31:0] bus_rdata,
  output wire        irq,
  input  wire        link_clk,
  input  wire        link_frame,
  input  wire        link_din,
  output wire        link_dout,
  output wire        link_rx_room
);

  localparam PADW = `JCU_FIELD_W - CW;
  localparam [CW-1:0] DEPTH_C = DEPTH;
  localparam [CW-1:0] LEVEL_C = `JCU_IRQ_LEVEL;
  localparam [CW-1:0] ONE_C   = 1;
  localparam [`JCU_BIT_W-1:0] BIT_ONE = 1;

  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_BITS = 2'h2;

  // Address match, shared by the read and write decoders.
  function hit;
    input [31:0] addr;
    input [31:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // Zero-extends a FIFO count into a 16-bit register field.
  function [`JCU_FIELD_W-1:0] widen;
    input [CW-1:0] value;
    begin
      widen = {{PADW{1'b0}}, value};
    end
  endfunction

  // True while a FIFO level lies above the interrupt threshold.
  function above_level;
    input [CW-1:0] value;
    begin
      above_level = (value > LEVEL_C);
    end
  endfunction

  // Bus decode.
  wire data_rd;
  wire data_wr;
  wire ctrl_rd;
  wire ctrl_wr;

  assign data_rd = bus_re & hit(bus_addr, `JCU_DATA_ADDR); // R01
  assign ctrl_rd = bus_re & hit(bus_addr, `JCU_CTRL_ADDR); // R01
  assign data_wr = bus_we & hit(bus_addr, `JCU_DATA_ADDR); // R01
  assign ctrl_wr = bus_we & hit(bus_addr, `JCU_CTRL_ADDR); // R01

  // Control state.
  reg        rx_ie_q;
  reg        tx_ie_q;
  reg        rx_ip_q;
  reg        tx_ip_q;
  reg        seen_q;
  reg        irq_q;
  reg        room_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // Link synchronisers: stage 0 feeds stage 1 only, stage 2 is for edges.
  // The extra edge stage costs one cycle per link edge, which the slow
  // host clock easily absorbs.
  reg [`JCU_SYNC_W-1:0] lclk_q;
  reg [`JCU_SYNC_W-1:0] lfrm_q;
  reg [`JCU_SYNC_W-1:0] ldin_q;

  wire lclk_rise;
  wire lclk_fall;
  wire frame_start;
  wire frame_on;
  wire din_s;

  assign lclk_rise   = lclk_q[1] & ~lclk_q[2];
  assign lclk_fall   = ~lclk_q[1] & lclk_q[2];
  assign frame_start = lfrm_q[1] & ~lfrm_q[2];
  assign frame_on    = lfrm_q[1];
  assign din_s       = ldin_q[1];

  always @(posedge clk) begin
    if (rst) begin
      lclk_q <= {`JCU_SYNC_W{1'b0}};
      lfrm_q <= {`JCU_SYNC_W{1'b0}};
      ldin_q <= {`JCU_SYNC_W{1'b0}};
    end else begin
      lclk_q <= {lclk_q[1:0], link_clk};
      lfrm_q <= {lfrm_q[1:0], link_frame};
      ldin_q <= {ldin_q[1:0], link_din};
    end
  end

  // Link frame engine. There is no timeout: a host that stops clocking
  // mid-frame leaves the engine waiting until link_frame drops.
  reg [1:0]              st_q;
  reg [`JCU_BIT_W-1:0]   bit_q;
  reg [`JCU_FRAME_W-1:0] rxsh_q;
  reg [`JCU_FRAME_W-1:0] txsh_q;
  reg                    dout_q;

  wire [`JCU_FRAME_W-1:0] rx_word;
  wire                    frame_end;

  assign rx_word   = {din_s, rxsh_q[`JCU_FRAME_W-1:1]};
  assign frame_end = (st_q == ST_BITS) & frame_on & lclk_rise & (bit_q == `JCU_LAST_BIT);

  // Receive FIFO.
  wire                   rx_in_valid;
  wire                   rx_in_ready;
  wire                   rx_valid;
  wire [`JCU_CHAR_W-1:0] rx_char;
  wire [CW-1:0]          rx_count;

  // A flagged character is offered only at the end of a whole frame.
  assign rx_in_valid = frame_end & rx_word[0];

  jcu_fifo #(
    .WIDTH (`JCU_CHAR_W),
    .DEPTH (DEPTH),
    .AW    (AW),
    .CW    (CW)
  ) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word[`JCU_FRAME_W-1:1]),
    .out_valid (rx_valid),
    .out_ready (data_rd),
    .out_data  (rx_char),
    .count     (rx_count)
  ); // R02 R04 R06 R09

  // Transmit FIFO, then a two-entry buffer that the frame engine drains.
  wire                   tx_in_ready;
  wire                   tx_mid_valid;
  wire                   tx_mid_ready;
  wire [`JCU_CHAR_W-1:0] tx_mid_data;
  wire [CW-1:0]          tx_count;
  wire                   skid_valid;
  wire                   skid_ready;
  wire [`JCU_CHAR_W-1:0] skid_data;
  wire [CW-1:0]          tx_room;

  // The link buffer is not counted, so software may place up to two more
  // characters than tx_room shows before writes start to be dropped.
  assign tx_room = DEPTH_C - tx_count; // R10

  jcu_fifo #(
    .WIDTH (`JCU_CHAR_W),
    .DEPTH (DEPTH),
    .AW    (AW),
    .CW    (CW)
  ) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (data_wr),
    .in_ready  (tx_in_ready),
    .in_data   (bus_wdata[`JCU_CHAR_MSB:`JCU_CHAR_LSB]),
    .out_valid (tx_mid_valid),
    .out_ready (tx_mid_ready),
    .out_data  (tx_mid_data),
    .count     (tx_count)
  ); // R08 R11

  // The buffer is only popped once a frame has carried its head out, so
  // a host that stops clocking stalls it and the transmit FIFO behind it.
  assign skid_ready = frame_end & txsh_q[0];

  jcu_fifo #(
    .WIDTH (`JCU_CHAR_W),
    .DEPTH (`JCU_SKID_DEPTH),
    .AW    (`JCU_SKID_AW),
    .CW    (`JCU_SKID_CW)
  ) u_tx_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_mid_valid),
    .in_ready  (tx_mid_ready),
    .in_data   (tx_mid_data),
    .out_valid (skid_valid),
    .out_ready (skid_ready),
    .out_data  (skid_data),
    .count     ()
  );

  always @(posedge clk) begin
    if (rst) begin
      st_q   <= ST_IDLE;
      bit_q  <= {`JCU_BIT_W{1'b0}};
      rxsh_q <= {`JCU_FRAME_W{1'b0}};
      txsh_q <= {`JCU_FRAME_W{1'b0}};
      dout_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (frame_start) begin
            // The head is latched so a late buffer change cannot tear it.
            txsh_q <= {skid_data, skid_valid};
            dout_q <= skid_valid;
            bit_q  <= {`JCU_BIT_W{1'b0}};
            st_q   <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (!frame_on) begin
            // A frame cut short moves nothing in either direction.
            st_q <= ST_IDLE;
          end else if (lclk_rise) begin
            rxsh_q <= rx_word;
            bit_q  <= bit_q + BIT_ONE;
            if (bit_q == `JCU_LAST_BIT) begin
              st_q <= ST_IDLE;
            end
          end else if (lclk_fall) begin
            dout_q <= txsh_q[bit_q];
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data, captured in the strobe cycle and shown in the next.
  always @* begin
    rdata_d = `JCU_WORD_ZERO;
    if (data_rd) begin
      if (rx_valid) begin
        rdata_d[`JCU_FIELD_MSB:`JCU_FIELD_LSB] = widen(rx_count - ONE_C); // R03 R06
      end
      rdata_d[`JCU_RX_VALID_BIT] = rx_valid; // R05 R07
      // An empty read still shows the stale head character, so software
      // must test the valid bit before using the byte.
      rdata_d[`JCU_CHAR_MSB:`JCU_CHAR_LSB] = rx_char; // R06
    end else if (ctrl_rd) begin
      rdata_d[`JCU_FIELD_MSB:`JCU_FIELD_LSB] = widen(tx_room); // R10
      rdata_d[`JCU_HOST_SEEN_BIT] = seen_q; // R12
      rdata_d[`JCU_TX_IP_BIT] = tx_ip_q; // R14
      rdata_d[`JCU_RX_IP_BIT] = rx_ip_q; // R14
      rdata_d[`JCU_TX_IE_BIT] = tx_ie_q; // R14
      rdata_d[`JCU_RX_IE_BIT] = rx_ie_q; // R14
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= `JCU_WORD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Control register and host-seen flag.
  always @(posedge clk) begin
    if (rst) begin
      rx_ie_q <= 1'b0;
      tx_ie_q <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        rx_ie_q <= bus_wdata[`JCU_RX_IE_BIT]; // R14
        tx_ie_q <= bus_wdata[`JCU_TX_IE_BIT]; // R14
      end
      // A link access in the same cycle as the clear keeps the flag set.
      if (frame_start) begin
        seen_q <= 1'b1; // R12
      end else if (ctrl_wr & bus_wdata[`JCU_HOST_SEEN_BIT]) begin
        seen_q <= 1'b0; // R13
      end
    end
  end

  // Interrupts follow the FIFO levels, so draining the receive side or
  // filling the transmit side lowers them with no separate clear.
  always @(posedge clk) begin
    if (rst) begin
      rx_ip_q <= 1'b0;
      tx_ip_q <= 1'b0;
      irq_q   <= 1'b0;
      room_q  <= 1'b0;
    end else begin
      rx_ip_q <= rx_ie_q & above_level(rx_count); // R15 R16
      tx_ip_q <= tx_ie_q & above_level(tx_room); // R15 R16
      irq_q   <= (rx_ip_q & rx_ie_q) | (tx_ip_q & tx_ie_q); // R17
      room_q  <= rx_in_ready; // R18
    end
  end

  assign bus_rdata    = rdata_q;
  assign irq          = irq_q;
  assign link_dout    = dout_q;
  assign link_rx_room = room_q;

endmodule

// ---- sim/jcu_uart_chk.sv ----
// Checker for the register port and interrupt pin of the character UART.
`include "jcu_defines.vh"
module jcu_uart_chk #(
  parameter DEPTH = 64
) (
  input logic        clk,
  input logic        rst,
  input logic [31:0] bus_addr,
  input logic [31:0] bus_wdata,
  input logic        bus_we,
  input logic        bus_re,
  input logic [31:0] bus_rdata,
  input logic        irq,
  input logic        link_clk,
  input logic        link_frame,
  input logic        link_din,
  input logic        link_dout,
  input logic        link_rx_room
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_drd;
    bus_re && bus_addr == `JCU_DATA_ADDR;
  endsequence
  sequence s_crd;
    bus_re && bus_addr == `JCU_CTRL_ADDR;
  endsequence
  AST_IDLE_ZERO: assert property (!bus_re |=> bus_rdata == 32'h0)
    else $error("read data not zero when idle");
  AST_UNMAPPED: assert property (bus_re && bus_addr != `JCU_DATA_ADDR &&
    bus_addr != `JCU_CTRL_ADDR |=> bus_rdata == 32'h0) else $error("unmapped read not zero");
  AST_DATA_UNUSED: assert property (s_drd |=> bus_rdata[14:8] == 7'h00)
    else $error("data word unused bits set");
  AST_EMPTY_READ: assert property (s_drd |=> bus_rdata[15] || bus_rdata[31:16] == 16'h0)
    else $error("empty read with count");
  AST_RX_BOUND: assert property (s_drd |=> bus_rdata[31:16] < DEPTH)
    else $error("receive count too large");
  AST_ROOM_BOUND: assert property (s_crd |=> bus_rdata[31:16] <= DEPTH)
    else $error("transmit room too large");
  AST_CTRL_UNUSED: assert property (s_crd |=> bus_rdata[15:11] == 5'h0 &&
    bus_rdata[7:2] == 6'h0) else $error("control unused bits set");
  AST_PEND_GATED: assert property (s_crd |=> (bus_rdata[9:8] & ~bus_rdata[1:0]) == 2'b00)
    else $error("pending without enable");
  AST_IRQ_OFF: assert property (bus_we && bus_addr == `JCU_CTRL_ADDR &&
    bus_wdata[1:0] == 2'b00 |-> ##[2:4] !irq) else $error("irq stays with enables off");
endmodule

bind jcu_uart jcu_uart_chk #(.DEPTH(DEPTH)) u_jcu_uart_chk (.clk(clk), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
  .bus_rdata(bus_rdata), .irq(irq), .link_clk(link_clk), .link_frame(link_frame),
  .link_din(link_din), .link_dout(link_dout), .link_rx_room(link_rx_room));

// ---- sim/jcu_host_model.sv ----
// Host end of the serial debug link: framed, flag bit first, LSB-first character.
module jcu_host_model (
  output logic link_clk,
  output logic link_frame,
  output logic link_din,
  input  logic link_dout,
  input  logic link_rx_room
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       got_flag;
  logic [7:0] got_ch;
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_din = 1'b1;
  end
  // The link clock only runs inside a frame; the odd offset keeps it off the system edges.
  task automatic frame(input logic send, input logic force_it, input logic [7:0] ch);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {ch, send && (link_rx_room || force_it)};
    #17 link_din = tx[0];
    link_frame = 1'b1;
    #100;
    for (int i = 0; i < 9; i++) begin
      #200 link_clk = 1'b1;
      rx[i] = link_dout;
      #200 link_clk = 1'b0;
      if (i < 8) link_din = tx[i+1];
    end
    link_frame = 1'b0;
    link_din = ~link_din;
    #300;
    got_flag = rx[0];
    got_ch = rx[8:1];
  endtask
endmodule

// ---- sim/jcu_uart_test.sv ----
// Self-checking bench for the character UART against the host link model.
`include "jcu_defines.vh"
module jcu_uart_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 8;
  localparam logic [31:0] DA = `JCU_DATA_ADDR;
  localparam logic [31:0] CA = `JCU_CTRL_ADDR;
  logic        clk;
  logic        rst;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_we;
  logic        bus_re;
  logic [31:0] bus_rdata;
  logic        irq;
  logic        link_clk;
  logic        link_frame;
  logic        link_din;
  logic        link_dout;
  logic        link_rx_room;
  int          errors;
  int          comparisons;
  int          seed;
  logic [31:0] q;
  logic [7:0]  rxq[$];
  logic [7:0]  txq[$];

  jcu_uart #(.DEPTH(DEPTH), .AW(3), .CW(4)) u_jcu_uart (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .irq(irq), .link_clk(link_clk), .link_frame(link_frame),
    .link_din(link_din), .link_dout(link_dout), .link_rx_room(link_rx_room));
  jcu_host_model u_jcu_host_model (.link_clk(link_clk), .link_frame(link_frame),
    .link_din(link_din), .link_dout(link_dout), .link_rx_room(link_rx_room));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] word(input int cnt, input logic [7:0] mid, input logic [7:0] lo);
    return {cnt[15:0], mid, lo};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_re <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask

  initial begin
    #1_000_000;
    errors++;
    wrap_up();
  end

  initial begin
    seed = 32'h4202;
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    bus_addr = 32'h0;
    bus_wdata = 32'h0;
    bus_we = 1'b0;
    bus_re = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(DA, q);
    chk("empty data", word(0, 8'h00, q[7:0]), q);
    rd(CA, q);
    chk("ctrl reset", word(DEPTH, 8'h00, 8'h00), q);
    rd(32'h10001008, q);
    chk("unmapped", 32'h0, q);
    // One character past full is forced onto the link; the device must drop it.
    for (int i = 0; i <= DEPTH; i++) begin
      rxq.push_back(8'($random(seed)));
      u_jcu_host_model.frame(1'b1, i == DEPTH, rxq[i]);
    end
    void'(rxq.pop_back());
    chk("rx room full", 32'h0, {31'h0, link_rx_room});
    rd(CA, q);
    chk("seen set", word(DEPTH, 8'h04, 8'h00), q);
    wr(CA, 32'h00000001);
    q = $random(seed);
    txq.push_back(q[7:0]);
    wr(DA, q);
    repeat (4) @(negedge clk);
    chk("rx irq", 32'h1, {31'h0, irq});
    rd(CA, q);
    chk("rx pending", word(DEPTH, 8'h05, 8'h01), q);
    wr(CA, 32'h00000401);
    rd(CA, q);
    chk("seen clear", word(DEPTH, 8'h01, 8'h01), q);
    for (int i = 0; i < DEPTH; i++) begin
      rd(DA, q);
      chk("rx pop", word(DEPTH - 1 - i, 8'h80, rxq[i]), q);
    end
    rd(CA, q);
    chk("rx pend off", word(DEPTH, 8'h00, 8'h01), q);
    chk("rx room back", 32'h1, {31'h0, link_rx_room});
    wr(CA, 32'h00000002);
    for (int i = 0; i < DEPTH + 2; i++) begin
      q = $random(seed);
      if (i <= DEPTH) txq.push_back(q[7:0]);
      wr(DA, q);
    end
    repeat (4) @(posedge clk);
    rd(CA, q);
    chk("tx full", word(0, 8'h00, 8'h02), q);
    for (int i = 0; i <= DEPTH + 2; i++) begin
      u_jcu_host_model.frame(1'b0, 1'b0, 8'h00);
      chk("tx flag", {31'h0, i < DEPTH + 2}, {31'h0, u_jcu_host_model.got_flag});
      if (i < DEPTH + 2) chk("tx char", {24'h0, txq[i]}, {24'h0, u_jcu_host_model.got_ch});
    end
    rd(CA, q);
    chk("tx pending", word(DEPTH, 8'h06, 8'h02), q);
    chk("tx irq", 32'h1, {31'h0, irq});
    wr(CA, 32'h00000000);
    repeat (4) @(negedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
    wrap_up();
  end
endmodule
